/* File: hdl/oag_operand_address_generator.sv */
// operand address generator: register selection or memory effective address
// assumes decoder presents one request per cycle with a valid strobe and
// the register file supplies the selected bank's pair contents
`timescale 1ns/1ns

module oag_operand_address_generator
	import oag_pkg::*;
#(
	parameter logic [15:0] HSRAM_LO = OAG_HSRAM_LO_DEF,
	parameter logic [15:0] HSRAM_HI = OAG_HSRAM_HI_DEF
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// decoder request
	input wire logic req_valid,
	input wire oag_mode_t req_mode,
	input wire oag_implied_t req_implied,
	input wire logic [7:0] req_opcode,
	input wire logic req_word,
	input wire logic [2:0] req_reg_code,
	input wire logic [1:0] req_pair_code,
	input wire logic req_index_b,
	input wire logic [15:0] absolute_address_operand,
	input wire logic [7:0] req_imm8,
	// bank flags
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	// selected-bank register contents
	input wire logic [15:0] pointer_pair_one,
	input wire logic [15:0] base_pair,
	input wire logic [7:0] reg_b,
	input wire logic [7:0] reg_c,
	input wire logic [15:0] stack_ptr,
	// sfr registers allowing word access, one bit per even word slot
	input wire logic [15:0] sfr_word_ok_map,
	// register selection result
	output logic reg_sel_valid,
	output logic reg_sel_pair,
	output logic [4:0] reg_sel_index,
	output logic [4:0] reg_sel_dest_index,
	output logic [1:0] reg_sel_bank,
	// memory address result
	output logic mem_valid,
	output logic [15:0] mem_addr,
	output logic mem_word,
	output logic mem_to_ram,
	output logic mem_to_sfr,
	output logic mem_stack,
	output logic [15:0] mem_sp_next,
	// status
	output oag_status_t status
);

	// ==========================================================
	// elaboration checks
	// the stack window must be ordered and stay clear of the sfr page
	if (HSRAM_LO > HSRAM_HI) begin : g_bad_window
		$error("oag: high-speed ram window inverted");
	end
	if (HSRAM_HI >= OAG_SFR_BASE) begin : g_bad_window_top
		$error("oag: high-speed ram window reaches the sfr page");
	end

	// ==========================================================
	// implied and fixed-opcode overrides
	logic force_pair;
	logic [2:0] eff_reg_code;
	logic [1:0] eff_pair_code;
	logic [1:0] dest_pair_code;
	oag_mode_t eff_mode;

	always_comb begin
		force_pair = 1'b0;
		eff_reg_code = req_reg_code;
		eff_pair_code = req_pair_code;
		dest_pair_code = req_pair_code;
		eff_mode = req_mode;
		unique case (req_implied)
			OAG_I_UNSIGNED_MULTIPLY_OP: begin
				eff_reg_code = OAG_R_A;
				dest_pair_code = OAG_RP_AX;
				eff_mode = OAG_M_REG8;
			end
			OAG_I_UNSIGNED_WORD_DIVIDE_OP: begin
				force_pair = 1'b1;
				eff_pair_code = OAG_RP_AX;
				dest_pair_code = OAG_RP_AX;
				eff_mode = OAG_M_REG16;
			end
			OAG_I_ADJ_ADD, OAG_I_ADJ_SUB: begin
				eff_reg_code = OAG_R_A;
				eff_mode = OAG_M_REG8;
			end
			OAG_I_ROT_L, OAG_I_ROT_R: begin
				eff_reg_code = OAG_R_A;
				eff_mode = OAG_M_REG8;
			end
			OAG_I_NONE: begin
			end
			default: begin
			end
		endcase
		// with no implied op flagged, fixed encodings win over whatever the decoder passed
		if (req_implied == OAG_I_NONE && req_opcode == OAG_OP_MOV_A_DE) begin
			eff_mode = OAG_M_INDIRECT;
			eff_pair_code = OAG_RP_DE;
			eff_reg_code = OAG_R_A;
		end
		if (req_implied == OAG_I_NONE && req_opcode == OAG_OP_PUSH_DE) begin
			eff_mode = OAG_M_STACK_PUSH;
			eff_pair_code = OAG_RP_DE;
		end
	end

	// ==========================================================
	// register selection
	logic [4:0] sel_index;
	logic [4:0] dest_index;
	logic [1:0] bank;
	logic is_pair;

	assign is_pair = force_pair || (eff_mode == OAG_M_REG16);

	oag_bank_select u_bank (
		.bank_select_low(bank_select_low),
		.bank_select_high(bank_select_high),
		.reg_code(eff_reg_code),
		.pair_code(eff_pair_code),
		.is_pair(is_pair),
		.byte_index(sel_index),
		.bank(bank)
	);

	// destination is always a pair slot of the same bank
	assign dest_index = {bank, dest_pair_code, 1'b0};

	// ==========================================================
	// address arithmetic
	logic [7:0] index_byte;
	logic [15:0] based_sum;
	logic [15:0] base_operand;
	logic [7:0] offset_operand;

	assign index_byte = req_index_b ? reg_b : reg_c;
	assign base_operand = base_pair;
	assign offset_operand = (eff_mode == OAG_M_BASED_IDX) ? index_byte : req_imm8;

	oag_adder16 u_add (
		.base(base_operand),
		.offset(offset_operand),
		.sum(based_sum)
	);

	// ==========================================================
	// effective address
	logic [15:0] ea;
	logic is_mem;
	logic is_stack;
	logic mode_bad;
	logic saddr_high;
	logic [15:0] sfr_ea;
	logic [15:0] sp_next;
	logic [15:0] sp_touch;

	// low 32 codes fold up into the sfr page
	assign saddr_high = (req_imm8 < OAG_SADDR_WRAP);
	assign sfr_ea = OAG_SFR_BASE | {8'h00, req_imm8};
	assign is_stack = (eff_mode == OAG_M_STACK_PUSH)
		|| (eff_mode == OAG_M_STACK_POP);

	always_comb begin
		ea = 16'h0000;
		is_mem = 1'b1;
		mode_bad = 1'b0;
		sp_next = stack_ptr;
		sp_touch = stack_ptr;
		unique case (eff_mode)
			OAG_M_NONE, OAG_M_REG8, OAG_M_REG16: begin
				is_mem = 1'b0;
			end
			OAG_M_DIRECT: begin
				ea = absolute_address_operand;
			end
			OAG_M_SADDR: begin
				ea = {7'h7f, saddr_high, req_imm8};
			end
			OAG_M_SFR: begin
				ea = sfr_ea;
			end
			OAG_M_INDIRECT: begin
				ea = (eff_pair_code == OAG_RP_DE) ? pointer_pair_one : base_pair;
			end
			OAG_M_BASED, OAG_M_BASED_IDX: begin
				ea = based_sum;
			end
			OAG_M_STACK_PUSH: begin
				// pre-decrement by one or two bytes
				sp_next = stack_ptr - (req_word ? 16'h0002 : 16'h0001);
				ea = sp_next;
				sp_touch = stack_ptr - 16'h0001;
			end
			OAG_M_STACK_POP: begin
				ea = stack_ptr;
				sp_next = stack_ptr + (req_word ? 16'h0002 : 16'h0001);
				sp_touch = stack_ptr + (req_word ? 16'h0001 : 16'h0000);
			end
			default: begin
				// spare mode codes fault and never reach memory, but still raise reg_sel_valid
				is_mem = 1'b0;
				mode_bad = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// legality checks, one per refusal reason
	logic saddr_bad;
	logic sfr_gap;
	logic sfr_word_bad;
	logic stack_bad;
	logic fault;

	// an odd word would straddle two byte slots
	assign saddr_bad = (eff_mode == OAG_M_SADDR) && req_word && req_imm8[0];
	// external hole is refused for sfr addressing only; direct, indirect and based modes still reach it
	assign sfr_gap = (eff_mode == OAG_M_SFR) && (sfr_ea >= OAG_SFR_GAP_LO)
		&& (sfr_ea <= OAG_SFR_GAP_HI);

	always_comb begin
		sfr_word_bad = 1'b0;
		if (eff_mode == OAG_M_SFR && req_word) begin
			// only the top 32 bytes, FFE0H to FFFFH, have word-capable slots in the map
			if (req_imm8[0] || req_imm8[7:5] != 3'h7) begin
				sfr_word_bad = 1'b1;
			end else if (!sfr_word_ok_map[req_imm8[4:1]]) begin
				sfr_word_bad = 1'b1;
			end
		end
	end

	always_comb begin
		stack_bad = 1'b0;
		if (is_stack) begin
			// both bytes of a word transfer must sit inside the window
			if (ea < HSRAM_LO || ea > HSRAM_HI) begin
				stack_bad = 1'b1;
			end
			if (sp_touch < HSRAM_LO || sp_touch > HSRAM_HI) begin
				stack_bad = 1'b1;
			end
		end
	end

	assign fault = mode_bad || saddr_bad || sfr_gap || sfr_word_bad || stack_bad;

	// ==========================================================
	// routing
	logic in_ram_win;
	logic route_ram;
	logic route_sfr;

	assign in_ram_win = (ea >= OAG_SADDR_LO) && (ea <= OAG_RAM_TOP);

	always_comb begin
		route_ram = in_ram_win;
		if (eff_mode == OAG_M_SADDR) begin
			route_sfr = !in_ram_win;
		end else begin
			// other modes may land outside both areas
			route_sfr = (ea >= OAG_SFR_BASE);
		end
	end

	// ==========================================================
	// registered register-selection strobes
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_sel_valid <= 1'b0;
			reg_sel_pair <= 1'b0;
		end else begin
			reg_sel_valid <= req_valid && !is_mem;
			reg_sel_pair <= is_pair;
		end
	end

	// registered register indices
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_sel_index <= 5'h00;
			reg_sel_dest_index <= 5'h00;
			reg_sel_bank <= 2'h0;
		end else begin
			reg_sel_index <= sel_index;
			reg_sel_dest_index <= dest_index;
			reg_sel_bank <= bank;
		end
	end

	// ==========================================================
	// memory strobe; faulted requests never reach the bus
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mem_valid <= 1'b0;
			mem_word <= 1'b0;
		end else begin
			mem_valid <= req_valid && is_mem && !fault;
			mem_word <= req_word;
		end
	end

	// memory address
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mem_addr <= 16'h0000;
		end else begin
			mem_addr <= ea;
		end
	end

	// target area flags
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mem_to_ram <= 1'b0;
			mem_to_sfr <= 1'b0;
		end else begin
			mem_to_ram <= route_ram;
			mem_to_sfr <= route_sfr;
		end
	end

	// stack pointer side; the register file commits sp_next itself
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mem_stack <= 1'b0;
			mem_sp_next <= 16'h0000;
		end else begin
			mem_stack <= is_stack;
			mem_sp_next <= sp_next;
		end
	end

	// ==========================================================
	// status of the last request
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			status <= OAG_S_IDLE;
		end else if (!req_valid) begin
			status <= OAG_S_IDLE;
		end else if (fault) begin
			status <= OAG_S_FAULT;
		end else begin
			status <= OAG_S_OK;
		end
	end

endmodule // oag_operand_address_generator

/* File: hdl/oag_pkg.sv */
// operand address generator constants and types
// assumes a single cpu clock domain; no software-visible registers
//
// Functional notes
// - multiply takes multiplicand from accumulator, product goes to accumulator_pair
// - word divide uses accumulator_pair as dividend and quotient
// - decimal adjust add and subtract select the accumulator implicitly
// - digit rotate left and right select the accumulator implicitly
// - register addressing uses current bank and a 3-bit register field
// - byte codes X,A,C,B,E,D,L,H; pair codes AX,BC,DE,HL order
// - direct addressing uses 16-bit immediate unmodified as address
// - short direct reaches only FE20H to FF1FH via 8-bit immediate
// - short direct bit 8 is 1 for 00H-1FH, else 0; upper ones
// - word short direct operands must be at even addresses
// - sfr address is FF00H plus immediate, excluding FFD0H to FFDFH
// - word sfr operands need 16-bit capable register at even address
// - register indirect uses pointer_pair_one or base_pair of current bank
// - based adds zero-extended 8-bit offset to base_pair, carry dropped
// - based indexed adds zero-extended B or C to base_pair, carry dropped
// - stack accesses go through the stack pointer
// - stack accesses confined to internal high-speed ram
// - opcode 10000101 moves byte at pointer_pair_one into accumulator
// - opcode 10110101 pushes pointer_pair_one through the stack pointer
// - short direct FE20H-FEFFH goes to ram, rest to sfr

package oag_pkg;

	// ==========================================================
	// address map
	localparam logic [15:0] OAG_SADDR_LO = 16'hfe20;
	localparam logic [15:0] OAG_SADDR_HI = 16'hff1f;
	localparam logic [15:0] OAG_RAM_TOP = 16'hfeff;
	localparam logic [15:0] OAG_SFR_BASE = 16'hff00;
	localparam logic [15:0] OAG_SFR_GAP_LO = 16'hffd0;
	localparam logic [15:0] OAG_SFR_GAP_HI = 16'hffdf;
	localparam logic [7:0] OAG_SADDR_WRAP = 8'h20;
	localparam logic [15:0] OAG_HSRAM_LO_DEF = 16'hfb00;
	localparam logic [15:0] OAG_HSRAM_HI_DEF = 16'hfeff;
	localparam logic [15:0] OAG_WORD_SFR_MASK_RST = 16'h0000;

	// ==========================================================
	// register codes
	localparam logic [2:0] OAG_R_X = 3'h0;
	localparam logic [2:0] OAG_R_A = 3'h1;
	localparam logic [2:0] OAG_R_C = 3'h2;
	localparam logic [2:0] OAG_R_B = 3'h3;
	localparam logic [1:0] OAG_RP_AX = 2'h0;
	localparam logic [1:0] OAG_RP_BC = 2'h1;
	localparam logic [1:0] OAG_RP_DE = 2'h2;
	localparam logic [1:0] OAG_RP_HL = 2'h3;

	// ==========================================================
	// opcodes decoded directly
	localparam logic [7:0] OAG_OP_MOV_A_DE = 8'h85;
	localparam logic [7:0] OAG_OP_PUSH_DE = 8'hb5;

	// ==========================================================
	// addressing modes
	typedef enum logic [3:0] {
		OAG_M_NONE,
		OAG_M_REG8,
		OAG_M_REG16,
		OAG_M_DIRECT,
		OAG_M_SADDR,
		OAG_M_SFR,
		OAG_M_INDIRECT,
		OAG_M_BASED,
		OAG_M_BASED_IDX,
		OAG_M_STACK_PUSH,
		OAG_M_STACK_POP
	} oag_mode_t;

	// implied operations
	typedef enum logic [2:0] {
		OAG_I_NONE,
		OAG_I_UNSIGNED_MULTIPLY_OP,
		OAG_I_UNSIGNED_WORD_DIVIDE_OP,
		OAG_I_ADJ_ADD,
		OAG_I_ADJ_SUB,
		OAG_I_ROT_L,
		OAG_I_ROT_R
	} oag_implied_t;

	// request status
	typedef enum logic [1:0] {
		OAG_S_IDLE,
		OAG_S_OK,
		OAG_S_FAULT
	} oag_status_t;

endpackage

/* File: hdl/oag_bank_select.sv */
// bank decoder: flat register index from bank flags and register code
// assumes the register file is laid out as four banks of eight bytes
`timescale 1ns/1ns

module oag_bank_select
	import oag_pkg::*;
(
	// bank flags
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	// register code
	input wire logic [2:0] reg_code,
	input wire logic [1:0] pair_code,
	input wire logic is_pair,
	// flat index into the 32-byte file
	output logic [4:0] byte_index,
	output logic [1:0] bank
);

	// ==========================================================
	// bank and index
	always_comb begin
		bank = {bank_select_high, bank_select_low};
		if (is_pair) begin
			byte_index = {bank, pair_code, 1'b0};
		end else begin
			byte_index = {bank, reg_code};
		end
	end

endmodule // oag_bank_select

/* File: hdl/oag_adder16.sv */
// 16-bit base plus zero-extended byte offset, carry dropped
// assumes purely combinational use
`timescale 1ns/1ns

module oag_adder16 (
	// operands
	input wire logic [15:0] base,
	input wire logic [7:0] offset,
	// result
	output logic [15:0] sum
);

	// ==========================================================
	// modular add; the carry out of bit 15 is simply not kept
	logic [16:0] full;

	always_comb begin
		full = {1'b0, base} + {9'h000, offset};
		sum = full[15:0];
	end

endmodule // oag_adder16

/* File: bench/oag_regfile_model.sv */
// register file model: selected-bank contents on the generator inputs
// assumes bank flags and stack pointer value come from the bench
`timescale 1ns/1ns
// ==========================================
// model
module oag_regfile_model (
	// bank flags and stack pointer
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	input wire logic [15:0] sp_value,
	// selected-bank contents
	output logic [15:0] pointer_pair_one,
	output logic [15:0] base_pair,
	output logic [7:0] reg_b,
	output logic [7:0] reg_c,
	output logic [15:0] stack_ptr
);
	logic [1:0] bank;
	assign bank = {bank_select_high, bank_select_low};
	// values differ per bank so a wrong bank shows
	assign pointer_pair_one = {6'h04, bank, 8'h34};
	// base near the top so offsets carry out
	assign base_pair = {14'h3fff, bank};
	assign reg_b = {6'h20, bank};
	assign reg_c = {6'h30, bank};
	assign stack_ptr = sp_value;
endmodule // oag_regfile_model

/* File: bench/oag_asserts.sv */
// port checker for the operand address generator
// assumes one clock, sync active-high reset, answer one cycle later
`timescale 1ns/1ns
// ==========================================
// checker
module oag_asserts
	import oag_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire oag_mode_t req_mode,
	input wire oag_implied_t req_implied,
	input wire logic [7:0] req_opcode,
	input wire logic req_word,
	input wire logic [2:0] req_reg_code,
	input wire logic [15:0] absolute_address_operand,
	input wire logic [7:0] req_imm8,
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	input wire logic [15:0] pointer_pair_one,
	input wire logic [15:0] base_pair,
	input wire logic [4:0] reg_sel_index,
	input wire logic [4:0] reg_sel_dest_index,
	input wire logic mem_valid,
	input wire logic [15:0] mem_addr,
	input wire logic mem_to_ram,
	input wire oag_status_t status
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_plain;
		req_valid && req_implied == OAG_I_NONE && req_opcode == 8'h00;
	endsequence
	sequence s_fault;
		!mem_valid && status == OAG_S_FAULT;
	endsequence
	AST_SADDR: assert property (s_plain ##0 (req_mode == OAG_M_SADDR && !req_word) |=>
		mem_valid && mem_addr == {7'h7f, $past(req_imm8) < 8'h20, $past(req_imm8)}
		&& mem_to_ram == ($past(req_imm8) >= 8'h20)) else $error("short direct wrong");
	AST_ODD: assert property (s_plain ##0 (req_mode == OAG_M_SADDR && req_word && req_imm8[0])
		|=> s_fault) else $error("odd word short direct taken");
	AST_DIRECT: assert property (s_plain ##0 (req_mode == OAG_M_DIRECT) |=>
		mem_valid && mem_addr == $past(absolute_address_operand)) else $error("direct wrong");
	AST_GAP: assert property (s_plain ##0 (req_mode == OAG_M_SFR && req_imm8[7:4] == 4'hd)
		|=> s_fault) else $error("sfr gap taken");
	AST_BASED: assert property (s_plain ##0 (req_mode == OAG_M_BASED) |=>
		mem_addr == 16'($past(base_pair) + $past(req_imm8))) else $error("based wrong");
	AST_REG8: assert property (s_plain ##0 (req_mode == OAG_M_REG8) |=> reg_sel_index ==
		{$past(bank_select_high), $past(bank_select_low), $past(req_reg_code)})
		else $error("register select wrong");
	AST_MOVDE: assert property (req_valid && req_implied == OAG_I_NONE
		&& req_opcode == 8'h85 |=> mem_valid && mem_addr == $past(pointer_pair_one))
		else $error("indirect move wrong");
	AST_UNSIGNED_MULTIPLY_OP: assert property (req_valid && req_implied == OAG_I_UNSIGNED_MULTIPLY_OP |=>
		reg_sel_dest_index == {$past(bank_select_high), $past(bank_select_low), 3'h0})
		else $error("product target wrong");
endmodule // oag_asserts

bind oag_operand_address_generator oag_asserts oag_asserts_i (.ref_clk, .reset, .req_valid,
	.req_mode, .req_implied, .req_opcode, .req_word, .req_reg_code, .absolute_address_operand,
	.req_imm8, .bank_select_low, .bank_select_high, .pointer_pair_one, .base_pair,
	.reg_sel_index, .reg_sel_dest_index, .mem_valid, .mem_addr, .mem_to_ram, .status);

/* File: bench/test_operand_address_generator.sv */
// self-checking bench for the operand address generator
// assumes the register file model feeds the selected-bank inputs
`timescale 1ns/1ns
// ==========================================
// bench
module test_operand_address_generator
	import oag_pkg::*;
;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic req_valid = 1'b0;
	oag_mode_t req_mode = OAG_M_NONE;
	oag_implied_t req_implied = OAG_I_NONE;
	logic [7:0] req_opcode = 8'h00;
	logic req_word = 1'b0;
	logic [2:0] req_reg_code = 3'h0;
	logic [1:0] req_pair_code = 2'h0;
	logic req_index_b = 1'b0;
	logic [15:0] absolute_address_operand = 16'h0000;
	logic [7:0] req_imm8 = 8'h00;
	logic bank_select_low = 1'b0;
	logic bank_select_high = 1'b0;
	logic [15:0] sp_value = 16'hfe00;
	logic [15:0] sfr_word_ok_map = 16'h0000;
	logic [15:0] pointer_pair_one, base_pair, stack_ptr, mem_addr, mem_sp_next;
	logic [7:0] reg_b, reg_c;
	logic reg_sel_valid, reg_sel_pair, mem_valid, mem_word, mem_to_ram, mem_to_sfr, mem_stack;
	logic [4:0] reg_sel_index, reg_sel_dest_index;
	logic [1:0] reg_sel_bank;
	oag_status_t status;
	int errors = 0;
	int num_checks = 0;
	always #4 ref_clk = ~ref_clk;
	oag_regfile_model oag_regfile_model_i (.bank_select_low, .bank_select_high, .sp_value,
		.pointer_pair_one, .base_pair, .reg_b, .reg_c, .stack_ptr);
	oag_operand_address_generator oag_operand_address_generator_i (.ref_clk, .reset, .req_valid,
		.req_mode, .req_implied, .req_opcode, .req_word, .req_reg_code, .req_pair_code,
		.req_index_b, .absolute_address_operand, .req_imm8, .bank_select_low,
		.bank_select_high, .pointer_pair_one, .base_pair, .reg_b, .reg_c, .stack_ptr,
		.sfr_word_ok_map, .reg_sel_valid, .reg_sel_pair, .reg_sel_index, .reg_sel_dest_index,
		.reg_sel_bank, .mem_valid, .mem_addr, .mem_word, .mem_to_ram, .mem_to_sfr, .mem_stack,
		.mem_sp_next, .status);
	// ==========================================
	// shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// one request; answer stands for one cycle after the taking edge
	task automatic go(input oag_mode_t m, input logic [7:0] imm, input logic w);
		req_mode = m;
		req_imm8 = imm;
		req_word = w;
		req_valid = 1'b1;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic complete_run;
		if (errors == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_saddr;
		logic [7:0] v[5] = '{8'h00, 8'h1f, 8'h20, 8'h30, 8'hff};
		foreach (v[i]) begin
			go(OAG_M_SADDR, v[i], 1'b0);
			chk(mem_addr, {7'h7f, v[i] < 8'h20, v[i]});
			chk(mem_to_ram, v[i] >= 8'h20);
			chk(mem_to_sfr, v[i] < 8'h20);
		end
		go(OAG_M_SADDR, 8'h30, 1'b1);
		chk(mem_valid & mem_word, 1'b1);
		go(OAG_M_SADDR, 8'h31, 1'b1);
		chk(status, OAG_S_FAULT);
	endtask
	task automatic t_direct_sfr;
		logic [7:0] s[6] = '{8'h00, 8'hcf, 8'he0, 8'hff, 8'hd0, 8'hdf};
		logic [7:0] w[4] = '{8'he2, 8'he0, 8'he3, 8'h20};
		// external area reached here by direct addressing; sfr addressing refuses it
		absolute_address_operand = 16'hffd4;
		go(OAG_M_DIRECT, 8'h00, 1'b0);
		chk(mem_addr, 16'hffd4);
		foreach (s[i]) begin
			go(OAG_M_SFR, s[i], 1'b0);
			chk(mem_valid, i < 4);
			if (i < 4) chk(mem_addr, {8'hff, s[i]});
		end
		sfr_word_ok_map = 16'h0002;
		foreach (w[i]) begin
			go(OAG_M_SFR, w[i], 1'b1);
			chk(mem_valid, i == 0);
		end
	endtask
	task automatic t_banks;
		for (int b = 0; b < 4; b++) begin
			{bank_select_high, bank_select_low} = b[1:0];
			for (int r = 0; r < 8; r++) begin
				req_reg_code = r[2:0];
				go(OAG_M_REG8, 8'h00, 1'b0);
				chk(reg_sel_index, {b[1:0], r[2:0]});
			end
			for (int p = 0; p < 4; p++) begin
				req_pair_code = p[1:0];
				go(OAG_M_REG16, 8'h00, 1'b1);
				chk({reg_sel_pair, reg_sel_index}, {1'b1, b[1:0], p[1:0], 1'b0});
				chk(reg_sel_bank, b[1:0]);
				if (p < 2) continue;
				go(OAG_M_INDIRECT, 8'h00, 1'b0);
				chk(mem_addr, p == 2 ? {6'h04, b[1:0], 8'h34} : {14'h3fff, b[1:0]});
			end
			go(OAG_M_BASED, 8'hf3, 1'b0);
			chk(mem_addr, {14'h3fff, b[1:0]} + 16'h00f3);
			req_index_b = b[0];
			go(OAG_M_BASED_IDX, 8'h00, 1'b0);
			chk(mem_addr, {14'h3fff, b[1:0]}
				+ {8'h00, (b[0] ? {6'h20, b[1:0]} : {6'h30, b[1:0]})});
		end
	endtask
	task automatic t_stack;
		logic [15:0] sp[4] = '{16'hfe00, 16'hfb02, 16'hfb00, 16'h8000};
		foreach (sp[i]) begin
			sp_value = sp[i];
			go(OAG_M_STACK_PUSH, 8'h00, 1'b1);
			chk(mem_valid, i < 2);
			if (i < 2) chk(mem_sp_next, sp[i] - 16'h0002);
		end
		sp_value = 16'hfefe;
		go(OAG_M_STACK_POP, 8'h00, 1'b1);
		chk(mem_addr, 16'hfefe);
		chk(mem_sp_next, 16'hff00);
		sp_value = 16'hfe00;
		req_opcode = 8'hb5;
		go(OAG_M_NONE, 8'h00, 1'b1);
		chk({mem_stack, mem_addr}, {1'b1, 16'hfdfe});
		req_opcode = 8'h85;
		go(OAG_M_NONE, 8'h00, 1'b0);
		chk(mem_addr, {6'h04, 2'h3, 8'h34});
		req_opcode = 8'h00;
	endtask
	task automatic t_implied;
		oag_implied_t ops[6] = '{OAG_I_UNSIGNED_MULTIPLY_OP, OAG_I_UNSIGNED_WORD_DIVIDE_OP, OAG_I_ADJ_ADD, OAG_I_ADJ_SUB,
			OAG_I_ROT_L, OAG_I_ROT_R};
		{bank_select_high, bank_select_low} = 2'h2;
		// operand field points elsewhere so only the implied choice fits
		req_reg_code = 3'h7;
		foreach (ops[i]) begin
			req_implied = ops[i];
			go(OAG_M_REG8, 8'h00, 1'b0);
			chk(reg_sel_valid, 1'b1);
			chk(reg_sel_index, {2'h2, i == 1 ? 3'h0 : 3'h1});
			if (i < 2) chk(reg_sel_dest_index, 5'h10);
		end
		req_implied = OAG_I_NONE;
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		chk(status, OAG_S_IDLE);
		t_saddr();
		t_direct_sfr();
		t_banks();
		{bank_select_high, bank_select_low} = 2'h3;
		t_stack();
		t_implied();
		req_valid = 1'b0;
		@(posedge ref_clk);
		#1;
		chk(mem_valid | reg_sel_valid, 1'b0);
		complete_run();
	end
	initial begin
		#100000;
		errors++;
		complete_run();
	end
endmodule // test_operand_address_generator
